// ---- include/phsps_regs.svh ----
// Register offsets, reset values and timing counts of the PCI pin select block.
`ifndef PHSPS_REGS_SVH
`define PHSPS_REGS_SVH
// Byte offsets of the register words.
`define PHSPS_OFS_CTRL     4'h0
`define PHSPS_OFS_STATUS   4'h4
`define PHSPS_OFS_GPIO     4'h8
`define PHSPS_OFS_CFGDATA  4'hC
// Control word bit positions.
`define PHSPS_CTRL_REQ     0
`define PHSPS_CTRL_INTA    1
`define PHSPS_CTRL_LOAD    2
// Control word reset value.
`define PHSPS_CTRL_RST     3'h0
// Boot mode code that means boot from PCI.
`define PHSPS_BOOT_PCI     2'h3
// Strap bit positions within the three upper address pins.
`define PHSPS_STRAP_HOST   2
`define PHSPS_STRAP_BOOT   1:0
// Strap settle cycles after reset release.
`define PHSPS_STRAP_WAIT   2'h2
// Serial memory read command and its length.
`define PHSPS_CMD_READ     8'h03
`define PHSPS_CMD_BITS     6'h08
`define PHSPS_DATA_BITS    6'h20
// Serial clock half period in ns and the system clock period.
`define PHSPS_SK_HALF_NS   500
`define PHSPS_CLK_NS       10
`define PHSPS_SK_HALF_CYC  ((`PHSPS_SK_HALF_NS + `PHSPS_CLK_NS - 1) / `PHSPS_CLK_NS)
`endif

// ---- include/phsps_pkg.sv ----
// Types shared by the PCI pin select block.
package phsps_pkg;
  // Avalon-MM request from the master.
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } phsps_av_req_s;
  // Avalon-MM answer to the master.
  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } phsps_av_rsp_s;
  // A pin split into its output value and its output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } phsps_pin_s;
  // Serial loader states.
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_CMD  = 2'b01,
    LD_DATA = 2'b10
  } phsps_ld_e;
endpackage

// ---- core/phsps_top.sv ----
// PCI grant, interrupt and serial configuration pin select with its register slave.
// Overview of operation
// (RL1) Grant 0: host output, satellite input.
// (RL2) Grant 2 pin becomes interrupt A.
// (RL3) Grant 1 pin becomes memory chip select.
// (RL4) Drive serial data out (shares GPIO 11).
// (RL5) Sample serial data in (shares GPIO 8).
// (RL6) Drive serial clock (shares GPIO 10).
// (RL7) Lock is only an input.
// (RL8) Upper address straps pick host and boot.
// (RL9) Request 0 output in satellite mode.
// (RL10) PCI reset asserts warm reset on boot.
// (RL11) One grant at most; none in satellite.
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`include "phsps_regs.svh"
module phsps_top (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  input  wire phsps_pkg::phsps_av_req_s avReq,
  output phsps_pkg::phsps_av_rsp_s    avRsp,
  input  wire logic                   pciClk,
  input  wire logic                   pciRstN,
  input  wire logic [2:0]             pciReqN,
  input  wire logic [2:0]             gntIn,
  output phsps_pkg::phsps_pin_s [2:0] gntPin,
  output phsps_pkg::phsps_pin_s       req0Pin,
  input  wire logic                   lockN,
  input  wire logic [2:0]             strapIn,
  input  wire logic                   sdiIn,
  output phsps_pkg::phsps_pin_s       sdiPin,
  input  wire logic                   sdoIn,
  output phsps_pkg::phsps_pin_s       sdoPin,
  input  wire logic                   skIn,
  output phsps_pkg::phsps_pin_s       cfgSerialClock,
  output logic                        warmRstN
);
  import phsps_pkg::*;

  // Two-stage synchronisers for every pin input except grant 1, grant 2 and serial clock in; stage one feeds stage two only.
  logic [11:0] syncA;
  logic [11:0] syncB;
  logic [11:0] pinRaw;
  logic        pciClkD;          // Delayed synced PCI clock for edge finding.
  assign pinRaw = {pciClk, pciRstN, pciReqN, gntIn[0], lockN, strapIn, sdiIn, sdoIn};

  // Synced pin views.
  logic       pciClkS;
  logic       pciRstS;
  logic [2:0] reqNS;
  logic       gnt0S;
  logic       lockS;
  logic [2:0] strapS;
  logic       sdiS;
  logic       pciRise;
  assign {pciClkS, pciRstS, reqNS, gnt0S, lockS, strapS, sdiS} = syncB[11:1];
  assign pciRise = pciClkS & ~pciClkD;

  // Synchroniser flops carry data only, so they need no reset.
  always_ff @(posedge clock) begin
    if (ce) begin
      syncA   <= pinRaw;
      syncB   <= syncA;
      pciClkD <= syncB[11];
    end
  end

  // Strap capture state.
  logic       hostMode;
  logic [1:0] bootMode;
  logic       strapDone;
  logic [1:0] strapCnt;
  logic       next_hostMode;
  logic [1:0] next_bootMode;
  logic       next_strapDone;
  logic [1:0] next_strapCnt;
  logic       bootPci;
  assign bootPci = (bootMode == `PHSPS_BOOT_PCI);

  // (RL8) strap capture once
  // Straps are taken once the synchronisers hold post-reset pin levels.
  always_comb begin
    next_hostMode  = hostMode;
    next_bootMode  = bootMode;
    next_strapDone = strapDone;
    next_strapCnt  = strapCnt;
    if (!strapDone) begin
      if (strapCnt == `PHSPS_STRAP_WAIT) begin
        next_hostMode  = strapS[`PHSPS_STRAP_HOST];
        next_bootMode  = strapS[`PHSPS_STRAP_BOOT];
        next_strapDone = 1'b1;
      end else begin
        next_strapCnt = strapCnt + 2'h1;
      end
    end
  end

  // Strap registers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hostMode  <= 1'b1;
      bootMode  <= 2'h0;
      strapDone <= 1'b0;
      strapCnt  <= 2'h0;
    end else if (ce) begin
      hostMode  <= next_hostMode;
      bootMode  <= next_bootMode;
      strapDone <= next_strapDone;
      strapCnt  <= next_strapCnt;
    end
  end

  // PCI-side logic is held in reset by the PCI reset pin as well.
  logic pciLogicRst;
  assign pciLogicRst = sys_rst | ~pciRstS;

  // Arbiter: grant index (3 means none) and round-robin pointer.
  logic [1:0] grant;
  logic [1:0] rrPtr;
  logic [1:0] next_grant;
  logic [1:0] next_rrPtr;
  logic [1:0] idx;

  // (RL11) single grant arbiter
  // A released grant idles one PCI clock so two grants never overlap on the bus.
  always_comb begin
    next_grant = grant;
    next_rrPtr = rrPtr;
    idx        = 2'h0;
    if (!hostMode || !strapDone) begin
      next_grant = 2'h3;
    end else if (pciRise) begin
      if (grant != 2'h3) begin
        if (reqNS[grant]) begin
          next_grant = 2'h3;
        end
      end else begin
        for (int i = 2; i >= 0; i--) begin
          idx = 2'((int'(rrPtr) + i) % 3);
          if (!reqNS[idx]) begin
            next_grant = idx;
            next_rrPtr = (idx == 2'h2) ? 2'h0 : idx + 2'h1;
          end
        end
      end
    end
  end

  // Arbiter registers.
  always_ff @(posedge clock) begin
    if (pciLogicRst) begin
      grant <= 2'h3;
      rrPtr <= 2'h0;
    end else if (ce) begin
      grant <= next_grant;
      rrPtr <= next_rrPtr;
    end
  end

  // Software registers.
  logic [2:0]  ctrl;
  logic [5:0]  gpio;             // Out values then enables of GPIO 8, 10, 11.
  logic [31:0] cfgData;
  logic [2:0]  next_ctrl;
  logic [5:0]  next_gpio;
  logic        ack;
  logic        next_ack;
  logic        busy;             // Loader active; reported in the status word.
  logic [31:0] next_rdata;
  logic        busWr;
  logic        loadGo;
  assign busWr  = ack & avReq.write;
  assign loadGo = busWr & (avReq.address == `PHSPS_OFS_CTRL) & avReq.writedata[`PHSPS_CTRL_LOAD];

  // Avalon slave: waitrequest drops one cycle after a request; write lands then.
  always_comb begin
    next_ack  = (avReq.read | avReq.write) & ~ack;
    next_ctrl = ctrl;
    next_gpio = gpio;
    if (busWr && avReq.address == `PHSPS_OFS_CTRL) begin
      next_ctrl = avReq.writedata[2:0];
    end
    if (busWr && avReq.address == `PHSPS_OFS_GPIO) begin
      next_gpio = avReq.writedata[5:0];
    end
    // The load bit is a command; it does not stay set.
    next_ctrl[`PHSPS_CTRL_LOAD] = 1'b0;
    case (avReq.address)
      `PHSPS_OFS_CTRL:    next_rdata = {29'h0, ctrl};
      // (RL7) lock observed only
      `PHSPS_OFS_STATUS:  next_rdata = {22'h0, grant, ~lockS, ~gnt0S, busy, warmRstN, bootMode, hostMode, strapDone};
      `PHSPS_OFS_GPIO:    next_rdata = {26'h0, gpio};
      `PHSPS_OFS_CFGDATA: next_rdata = cfgData;
      default:            next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus registers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack          <= 1'b0;
      avRsp        <= '{waitrequest: 1'b1, readdata: 32'h0000_0000};
      ctrl         <= `PHSPS_CTRL_RST;
      gpio         <= 6'h00;
    end else if (ce) begin
      ack          <= next_ack;
      avRsp        <= '{waitrequest: ~next_ack, readdata: next_rdata};
      ctrl         <= next_ctrl;
      gpio         <= next_gpio;
    end
  end

  // Serial loader state.
  phsps_ld_e   ldState;
  phsps_ld_e   next_ldState;
  logic [6:0]  divCnt;
  logic [6:0]  next_divCnt;
  logic [5:0]  bitCnt;
  logic [5:0]  next_bitCnt;
  logic        skLvl;
  logic        next_skLvl;
  logic [7:0]  cmdSh;
  logic [7:0]  next_cmdSh;
  logic [31:0] next_cfgData;
  logic        autoDone;
  logic        next_autoDone;
  logic        halfTick;
  assign busy     = (ldState != LD_IDLE);
  assign halfTick = (divCnt == 7'(`PHSPS_SK_HALF_CYC - 1));

  // Loader runs in satellite boot-from-PCI mode after reset, or on software request in satellite mode.
  always_comb begin
    next_ldState  = ldState;
    next_divCnt   = busy ? (halfTick ? 7'h00 : divCnt + 7'h01) : 7'h00;
    next_bitCnt   = bitCnt;
    next_skLvl    = skLvl;
    next_cmdSh    = cmdSh;
    next_cfgData  = cfgData;
    next_autoDone = autoDone;
    case (ldState)
      LD_IDLE: begin
        next_skLvl = 1'b0;
        if (strapDone && !hostMode && ((bootPci && !autoDone) || loadGo)) begin
          next_ldState  = LD_CMD;
          next_autoDone = 1'b1;
          next_cmdSh    = `PHSPS_CMD_READ;
          next_bitCnt   = 6'h00;
        end
      end
      LD_CMD, LD_DATA: begin
        if (halfTick) begin
          next_skLvl = ~skLvl;
          if (skLvl) begin
            // (RL4) shift data out
            // Falling edge: present the next command bit.
            next_cmdSh  = {cmdSh[6:0], 1'b0};
            next_bitCnt = bitCnt + 6'h01;
            if (ldState == LD_CMD && bitCnt == `PHSPS_CMD_BITS - 6'h01) begin
              next_ldState = LD_DATA;
              next_bitCnt  = 6'h00;
            end else if (ldState == LD_DATA && bitCnt == `PHSPS_DATA_BITS - 6'h01) begin
              next_ldState = LD_IDLE;
            end
          end else if (ldState == LD_DATA) begin
            // (RL5) sample data in
            // Rising edge: the memory's output bit is taken.
            next_cfgData = {cfgData[30:0], sdiS};
          end
        end
      end
      default: next_ldState = LD_IDLE;
    endcase
  end

  // Loader registers.
  always_ff @(posedge clock) begin
    if (pciLogicRst) begin
      ldState  <= LD_IDLE;
      divCnt   <= 7'h00;
      bitCnt   <= 6'h00;
      skLvl    <= 1'b0;
      cmdSh    <= 8'h00;
      cfgData  <= 32'h0000_0000;
      autoDone <= 1'b0;
    end else if (ce) begin
      ldState  <= next_ldState;
      divCnt   <= next_divCnt;
      bitCnt   <= next_bitCnt;
      skLvl    <= next_skLvl;
      cmdSh    <= next_cmdSh;
      cfgData  <= next_cfgData;
      autoDone <= next_autoDone;
    end
  end

  // Pin mux: every pin output is a flop fed from the mode and the logic above.
  phsps_pin_s [2:0] next_gntPin;
  phsps_pin_s       next_req0Pin;
  phsps_pin_s       next_sdiPin;
  phsps_pin_s       next_sdoPin;
  phsps_pin_s       next_sk;
  logic             next_warmRstN;
  always_comb begin
    // (RL1) host drives grants
    for (int g = 0; g < 3; g++) begin
      next_gntPin[g] = '{o: ~(grant == 2'(g)), oe: hostMode & strapDone};
    end
    next_req0Pin = '{o: 1'b1, oe: 1'b0};
    if (!hostMode) begin
      // (RL11) satellite drives no grant
      next_gntPin[0] = '{o: 1'b1, oe: 1'b0};
      // (RL2) interrupt A open drain
      next_gntPin[2] = '{o: 1'b0, oe: ctrl[`PHSPS_CTRL_INTA]};
      // (RL3) chip select output
      next_gntPin[1] = '{o: busy, oe: 1'b1};
      // (RL9) own bus request
      next_req0Pin = '{o: ~ctrl[`PHSPS_CTRL_REQ], oe: 1'b1};
    end
    // (RL6) serial clock output
    next_sk     = busy ? phsps_pin_s'{o: skLvl, oe: 1'b1} : phsps_pin_s'{o: gpio[1], oe: gpio[4]};
    next_sdoPin = busy ? phsps_pin_s'{o: cmdSh[7], oe: 1'b1} : phsps_pin_s'{o: gpio[2], oe: gpio[5]};
    next_sdiPin = busy ? phsps_pin_s'{o: 1'b0, oe: 1'b0} : phsps_pin_s'{o: gpio[0], oe: gpio[3]};
    // (RL10) warm reset on PCI reset
    next_warmRstN = ~(~hostMode & bootPci & strapDone & ~pciRstS);
  end

  // Pin registers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gntPin         <= {3{2'b10}};
      req0Pin        <= 2'b10;
      sdiPin         <= 2'b00;
      sdoPin         <= 2'b00;
      cfgSerialClock <= 2'b00;
      warmRstN       <= 1'b1;
    end else if (ce) begin
      gntPin         <= next_gntPin;
      req0Pin        <= next_req0Pin;
      sdiPin         <= next_sdiPin;
      sdoPin         <= next_sdoPin;
      cfgSerialClock <= next_sk;
      warmRstN       <= next_warmRstN;
    end
  end

  // Checks of pin behaviour; all but one_grant_a and strap_hold_a hold only while the clock enable is high.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  one_grant_a: assert property ($onehot0({~gntPin[2].o, ~gntPin[1].o, ~gntPin[0].o} & {3{hostMode}})) // RL11
    else $error("More than one grant driven.");
  sat_no_grant_a: assert property (ce && !hostMode |=> !gntPin[0].oe) // RL1
    else $error("Grant 0 driven in satellite mode.");
  inta_pin_a: assert property (ce && !hostMode && ctrl[1] |=> gntPin[2].oe && !gntPin[2].o) // RL2
    else $error("Interrupt A not asserted.");
  chip_sel_a: assert property (ce && !hostMode && busy |=> gntPin[1].o && gntPin[1].oe) // RL3
    else $error("Chip select not high while loading.");
  data_out_a: assert property (ce && busy |=> sdoPin.oe && sdoPin.o == $past(cmdSh[7])) // RL4
    else $error("Serial data out wrong.");
  data_in_a: assert property (ce && busy |=> !sdiPin.oe) // RL5
    else $error("Serial data in driven.");
  ser_clock_a: assert property (ce && busy |=> cfgSerialClock.oe && cfgSerialClock.o == $past(skLvl)) // RL6
    else $error("Serial clock not following divider.");
  strap_hold_a: assert property (strapDone |=> $stable(hostMode) && $stable(bootMode)) // RL8
    else $error("Straps changed after capture.");
  req_out_a: assert property (ce && !hostMode |=> req0Pin.oe && req0Pin.o == !$past(ctrl[0])) // RL9
    else $error("Request 0 wrong in satellite mode.");
  warm_rst_a: assert property (ce && !hostMode && bootPci && strapDone && !pciRstS |=> !warmRstN) // RL10
    else $error("Warm reset missing.");
  host_grant_c: cover property (hostMode && !gntPin[1].o);
  load_done_c: cover property (busy ##1 !busy);
  inta_c: cover property (!hostMode && gntPin[2].oe);
endmodule // phsps_top

// ---- sim/phsps_far_model.sv ----
// Behavioural serial configuration memory that answers the block's loader.
module phsps_far_model #(
  parameter logic [31:0] WORD = 32'hA5C3_0F96
) (
  input  wire logic       cs,
  input  wire logic       sk,
  input  wire logic       sdo,
  output logic            sdi,
  output logic [7:0]      cmdSeen
);
  int bitNo = 0;  // Serial clock rises seen in this frame.
  initial sdi = 1'b1;
  // A new frame starts on the rising chip select.
  always @(posedge cs) begin
    bitNo = 0;
    cmdSeen = 8'h00;
  end
  // command bits in
  // The command arrives most significant bit first on the rising clock.
  always @(posedge sk) begin
    if (cs) begin
      if (bitNo < 8) cmdSeen = {cmdSeen[6:0], sdo};
      bitNo++;
    end
  end
  // word bits out
  // Data change on the falling clock so they are settled at the next rise.
  always @(negedge sk) begin
    if (cs && bitNo >= 8 && bitNo < 40) sdi = WORD[39-bitNo];
  end
  // line released
  // Once released the line carries no stale value, so it flips.
  always @(negedge cs) sdi = ~sdi;
endmodule // phsps_far_model

// ---- sim/tb_top.sv ----
// Testbench for the PCI pin select block: register tasks and pin scenarios.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import phsps_pkg::*;
  localparam logic [31:0] WORD = 32'hA5C3_0F96;  // Word held by the memory model.
  logic             clock = 1'b0;
  logic             sysRst = 1'b1;
  logic             ceOn = 1'b1;     // Clock enable of the block.
  logic             pciClk = 1'b0;
  logic             pciRstN = 1'b1;
  logic             lockN = 1'b1;
  logic             ownGntN = 1'b1;  // Grant handed to the device in satellite mode.
  logic [2:0]       pciReqN = 3'b111;
  logic [2:0]       strapIn = 3'b100;
  phsps_av_req_s    avReq = '0;
  phsps_av_rsp_s    avRsp;
  phsps_pin_s [2:0] gntPin;
  phsps_pin_s       req0Pin, sdiPin, sdoPin, skPin;
  logic             warmRstN, memSdi;
  logic [7:0]       cmdSeen;
  logic [31:0]      q;
  int               nErrors = 0, checkCount = 0, k, i;
  // Wire levels: released grant 1 and 2 pins fall back to their pull-up; grant 0 falls back to ownGntN and data in to the memory.
  wire logic [2:0]  gntIn = {gntPin[2].oe ? gntPin[2].o : 1'b1, gntPin[1].oe ? gntPin[1].o : 1'b1,
                             gntPin[0].oe ? gntPin[0].o : ownGntN};
  wire logic        sdiIn = sdiPin.oe ? sdiPin.o : memSdi;
  always #5 clock = ~clock;
  // The link clock is unrelated in phase to the system clock.
  initial #3 forever #62.5 pciClk = ~pciClk;
  phsps_top DUT (.clock(clock), .sys_rst(sysRst), .ce(ceOn), .avReq(avReq), .avRsp(avRsp), .pciClk(pciClk),
    .pciRstN(pciRstN), .pciReqN(pciReqN), .gntIn(gntIn), .gntPin(gntPin), .req0Pin(req0Pin), .lockN(lockN),
    .strapIn(strapIn), .sdiIn(sdiIn), .sdiPin(sdiPin), .sdoIn(sdoPin.oe ? sdoPin.o : 1'b1), .sdoPin(sdoPin),
    .skIn(skPin.oe ? skPin.o : 1'b1), .cfgSerialClock(skPin), .warmRstN(warmRstN));
  phsps_far_model #(.WORD(WORD)) MEM (.cs(gntPin[1].o & gntPin[1].oe), .sk(skPin.o), .sdo(sdoPin.o),
    .sdi(memSdi), .cmdSeen(cmdSeen));
  // Prints the verdict and ends the run.
  task automatic tallyAndFinish();
    if (nErrors == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One comparison; a mismatch is printed and counted.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      nErrors++;
    end
  endtask
  // A wait that ran out of its bound ends the run.
  task automatic guard(input logic ok);
    check({31'h0, ok}, 32'h1);
    if (ok !== 1'b1) tallyAndFinish();
  endtask
  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    avReq <= '{read: !wr, write: wr, address: a, writedata: d};
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (avRsp.waitrequest === 1'b0) break;
    end
    guard(n < 50);
    r = avRsp.readdata;
    avReq <= '0;
    @(posedge clock);
  endtask
  // Resets with the given straps and lets them be captured.
  task automatic doReset(input logic [2:0] s);
    strapIn <= s;
    sysRst <= 1'b1;
    repeat (20) @(posedge clock);
    sysRst <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  // Waits for the loader's chip select to fall, then checks the frame.
  task automatic loadDone();
    for (k = 0; k < 9000 && gntPin[1].o !== 1'b0; k++) @(posedge clock);
    guard(k < 9000);
    check({24'h0, cmdSeen}, 32'h0000_0003);
    bus(1'b0, 4'hC, 32'h0, q);
    check(q, WORD);
  endtask
  initial begin
    doReset(3'b100);
    bus(1'b0, 4'h4, 32'h0, q);
    check(q & 32'h0000_03BF, 32'h0000_0313);
    check({31'h0, req0Pin.oe}, 32'h0);
    // Each requester alone gets exactly its own grant.
    for (i = 0; i < 3; i++) begin
      pciReqN <= ~(3'b001 << i);
      for (k = 0; k < 300 && gntPin[i].o !== 1'b0; k++) @(posedge clock);
      guard(k < 300);
      check({29'h0, gntPin[2].o, gntPin[1].o, gntPin[0].o}, {29'h0, ~(3'b001 << i)});
      check({29'h0, gntPin[2].oe, gntPin[1].oe, gntPin[0].oe}, 32'h7);
      bus(1'b0, 4'h4, 32'h0, q);
      check({30'h0, q[9:8]}, i);
      pciReqN <= 3'b111;
      for (k = 0; k < 300 && gntPin[i].o !== 1'b1; k++) @(posedge clock);
      guard(k < 300);
    end
    // All three request together; exactly one grant may stand.
    pciReqN <= 3'b000;
    for (k = 0; k < 300 && {gntPin[2].o, gntPin[1].o, gntPin[0].o} === 3'b111; k++) @(posedge clock);
    guard(k < 300);
    check($countones(~{gntPin[2].o, gntPin[1].o, gntPin[0].o}), 32'h1);
    pciReqN <= 3'b111;
    for (k = 0; k < 300 && {gntPin[2].o, gntPin[1].o, gntPin[0].o} !== 3'b111; k++) @(posedge clock);
    guard(k < 300);
    lockN <= 1'b0;
    repeat (6) @(posedge clock);
    bus(1'b0, 4'h4, 32'h0, q);
    check({31'h0, q[7]}, 32'h1);
    lockN <= 1'b1;
    // Shared pins serve as general-purpose outputs outside loading.
    bus(1'b1, 4'h8, 32'h0000_003A, q);
    bus(1'b0, 4'h8, 32'h0, q);
    check(q, 32'h0000_003A);
    check({29'h0, sdoPin.o, skPin.o, sdiPin.o}, 32'h2);
    bus(1'b0, 4'h2, 32'h0, q);
    check(q, 32'h0);
    // Satellite mode booting from the link loads the word by itself.
    doReset(3'b011);
    for (k = 0; k < 300 && gntPin[1].o !== 1'b1; k++) @(posedge clock);
    guard(k < 300);
    check({30'h0, gntPin[1].oe, gntPin[0].oe}, 32'h2);
    loadDone();
    bus(1'b0, 4'h4, 32'h0, q);
    check(q & 32'h0000_003F, 32'h0000_001D);
    bus(1'b1, 4'h0, 32'h0000_0003, q);
    // The pins follow the control word one registered cycle after the write lands.
    @(posedge clock);
    check({28'h0, req0Pin.o, req0Pin.oe, gntPin[2].o, gntPin[2].oe}, 32'h5);
    ownGntN <= 1'b0;
    repeat (6) @(posedge clock);
    bus(1'b0, 4'h4, 32'h0, q);
    check({31'h0, q[6]}, 32'h1);
    bus(1'b1, 4'h0, 32'h0000_0000, q);
    @(posedge clock);
    check({30'h0, gntPin[2].oe, req0Pin.o}, 32'h1);
    // A software load reads back as zero and repeats the frame.
    bus(1'b1, 4'h0, 32'h0000_0004, q);
    bus(1'b0, 4'h0, 32'h0, q);
    check(q, 32'h0);
    loadDone();
    // Link reset in satellite boot pulls the warm reset, but not while the clock enable is low.
    ceOn <= 1'b0;
    pciRstN <= 1'b0;
    repeat (10) @(posedge clock);
    check({31'h0, warmRstN}, 32'h1);
    ceOn <= 1'b1;
    for (k = 0; k < 50 && warmRstN !== 1'b0; k++) @(posedge clock);
    guard(k < 50);
    pciRstN <= 1'b1;
    for (k = 0; k < 50 && warmRstN !== 1'b1; k++) @(posedge clock);
    guard(k < 50);
    tallyAndFinish();
  end
  // Cuts a hang short.
  initial begin
    #200us;
    nErrors++;
    tallyAndFinish();
  end
endmodule // tb_top
